// *** shared/mmbc_regs.svh ***
`ifndef MMBC_REGS_SVH
`define MMBC_REGS_SVH

// ----------------------------------------------------------------------
// Pin levels and timing of the minimum-mode bus control block
// ----------------------------------------------------------------------

// Memory/IO select levels
`define MMBC_MIO_MEM 1'b1
`define MMBC_MIO_IO 1'b0

// Transceiver direction levels
`define MMBC_DIR_TX 1'b1
`define MMBC_DIR_RX 1'b0

// Level that a floated control line settles to (weak pull-up)
`define MMBC_FLOAT_LVL 1'b1

// Inactive level of every active-low strobe
`define MMBC_STROBE_IDLE 1'b1

// Reference clock cycles per bus state, and the phase that ends one
`define MMBC_PHASES_PER_STATE 2
`define MMBC_PH_HIGH 1'b0
`define MMBC_PH_LOW 1'b1

// Reset values of the output drivers
`define MMBC_RST_DRIVE 1'b1
`define MMBC_RST_ALE 1'b0
`define MMBC_RST_GRANT 1'b0

`endif

// *** shared/mmbc_pkg.sv ***
// ----------------------------------------------------------------------
// Types of the minimum-mode bus control block
// ----------------------------------------------------------------------
package mmbc_pkg;

	// Bus states, Gray coded along idle, T1, T2, T3, wait, T4
	typedef enum logic [2:0]
	{
		MMBC_S_IDLE = 3'h0,
		MMBC_S_T1 = 3'h1,
		MMBC_S_T2 = 3'h3,
		MMBC_S_T3 = 3'h2,
		MMBC_S_TW = 3'h6,
		MMBC_S_T4 = 3'h7,
		MMBC_S_HOLD = 3'h5
	} mmbc_state_t;

endpackage

// *** src/mmbc_bus_control.sv ***
`timescale 1ns/1ns
`include "mmbc_regs.svh"

// What this block does
// - Memory/IO select high for memory, low for IO accesses.
// - Select valid from the state before a cycle until its last state.
// - Select floats, weak one, while the bus is granted away.
// - Store strobe low in second, third and wait states of writes.
// - Store strobe floats at logic one while the bus is granted away.
// - Acknowledge strobe low in second, third and wait states of its cycle.
// - Acknowledge strobe always driven, even while the bus is granted.
// - Address latch pulse high in the low clock phase of state one.
// - Address latch pulse always driven, including during a grant.
// - Direction high to transmit, low to receive, select timing.
// - Direction floats at logic one while the bus is granted away.
// - Transceiver enable low for memory, IO and acknowledge cycles.
// - Reads and acknowledges: enable from mid second to mid fourth state.
// - Writes: enable from start of second to mid fourth state.
// - Transceiver enable floats at logic one while granted away.
// - Grant rises mid final state or mid idle state.
// - Bus control lines float together with the grant rising.
// - Grant drops when request is low; drive again for next cycle.
module mmbc_bus_control
	import mmbc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic mode_strap_i,
	input wire logic bus_req_i,
	input wire logic ready_i,
	input wire logic cyc_req_i,
	input wire logic cyc_mem_i,
	input wire logic cyc_write_i,
	input wire logic cyc_irq_ack_strobe_n_i,
	output logic cyc_ack_o,
	output logic cyc_done_o,
	output logic mem_io_sel_o,
	output logic mem_io_sel_oe_o,
	output logic store_strobe_n_o,
	output logic store_strobe_n_oe_o,
	output logic irq_ack_strobe_n_o,
	output logic addr_latch_o,
	output logic xcvr_direction_o,
	output logic xcvr_direction_oe_o,
	output logic xcvr_output_enable_n_o,
	output logic xcvr_output_enable_n_oe_o,
	output logic bus_grant_out_o
);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------

	logic [2:0] pin_meta_r;
	logic [2:0] pin_sync_r;
	logic strap_s;
	logic hold_s;
	logic ready_s;

	// Two flops per pin; the first stage feeds nothing but the second
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			pin_meta_r <= 3'h0;
			pin_sync_r <= 3'h0;
		end
		else
		begin
			pin_meta_r <= {ready_i, bus_req_i, mode_strap_i};
			pin_sync_r <= pin_meta_r;
		end
	end

	assign strap_s = pin_sync_r[0];
	assign hold_s = pin_sync_r[1];
	assign ready_s = pin_sync_r[2];

	// ------------------------------------------------------------------
	// Bus state sequencer
	// ------------------------------------------------------------------

	// Each bus state not cut short by a grant is two reference cycles: clock high, then clock low
	mmbc_state_t st_r;
	mmbc_state_t st_nxt;
	logic ph_r;
	logic ph_nxt;
	logic start_r;
	logic start_nxt;
	logic wr_r;
	logic wr_nxt;
	logic irq_ack_strobe_n_r;
	logic irq_ack_strobe_n_nxt;
	logic mio_r;
	logic mio_nxt;
	logic drv_r;
	logic drv_nxt;
	logic dec_pt;
	logic take_hold;
	logic take_cyc;
	logic state_end;
	logic gap_state;

	// Decisions are made in the first half of an idle or final state
	assign gap_state = (st_r == MMBC_S_IDLE) || (st_r == MMBC_S_T4);
	assign dec_pt = gap_state && (ph_r == `MMBC_PH_HIGH) && !start_r;
	assign state_end = (ph_r == `MMBC_PH_LOW);

	// Hold wins over a new cycle so a waiting master is not starved
	assign take_hold = dec_pt && hold_s && strap_s;
	assign take_cyc = dec_pt && !hold_s && strap_s && cyc_req_i;

	// Grant cuts the state in half; otherwise states end on the low phase
	assign ph_nxt = take_hold ? `MMBC_PH_LOW : ~ph_r;
	assign start_nxt = take_cyc || (start_r && (st_nxt != MMBC_S_T1));

	// Cycle attributes are captured once, at the decision point
	assign wr_nxt = take_cyc ? (cyc_write_i && !cyc_irq_ack_strobe_n_i) : wr_r;
	assign irq_ack_strobe_n_nxt = take_cyc ? cyc_irq_ack_strobe_n_i : irq_ack_strobe_n_r;
	assign mio_nxt = take_cyc ? ((cyc_mem_i && !cyc_irq_ack_strobe_n_i) ?
		`MMBC_MIO_MEM : `MMBC_MIO_IO) : mio_r;

	// Drivers come back only for a new cycle after a grant
	assign drv_nxt = take_hold ? 1'b0 : (take_cyc ? 1'b1 : drv_r);

	// Next state; waits are added after the third state until ready
	always_comb
	begin
		st_nxt = st_r;
		if (take_hold)
			st_nxt = MMBC_S_HOLD;
		else if (state_end)
		begin
			unique case (st_r)
				MMBC_S_IDLE: st_nxt = start_r ? MMBC_S_T1 : MMBC_S_IDLE;
				MMBC_S_T1: st_nxt = MMBC_S_T2;
				MMBC_S_T2: st_nxt = MMBC_S_T3;
				MMBC_S_T3: st_nxt = ready_s ? MMBC_S_T4 : MMBC_S_TW;
				MMBC_S_TW: st_nxt = ready_s ? MMBC_S_T4 : MMBC_S_TW;
				MMBC_S_T4: st_nxt = start_r ? MMBC_S_T1 : MMBC_S_IDLE;
				MMBC_S_HOLD: st_nxt = hold_s ? MMBC_S_HOLD : MMBC_S_IDLE;
				default: st_nxt = MMBC_S_IDLE;
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			st_r <= MMBC_S_IDLE;
			ph_r <= `MMBC_PH_HIGH;
			start_r <= 1'b0;
			wr_r <= 1'b0;
			irq_ack_strobe_n_r <= 1'b0;
			mio_r <= `MMBC_FLOAT_LVL;
			drv_r <= `MMBC_RST_DRIVE;
		end
		else
		begin
			st_r <= st_nxt;
			ph_r <= ph_nxt;
			start_r <= start_nxt;
			wr_r <= wr_nxt;
			irq_ack_strobe_n_r <= irq_ack_strobe_n_nxt;
			mio_r <= mio_nxt;
			drv_r <= drv_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Pin decode from the next state
	// ------------------------------------------------------------------

	// Outputs are decoded from the next state so that each pin is a flop
	logic in_strobe;
	logic ale_nxt;
	logic wr_n_nxt;
	logic irq_ack_strobe_n_n_nxt;
	logic den_on;
	logic dir_nxt;
	logic done_nxt;

	assign in_strobe = (st_nxt == MMBC_S_T2) || (st_nxt == MMBC_S_T3) ||
		(st_nxt == MMBC_S_TW);
	assign ale_nxt = (st_nxt == MMBC_S_T1) && (ph_nxt == `MMBC_PH_LOW);
	assign wr_n_nxt = !(wr_r && in_strobe);
	assign irq_ack_strobe_n_n_nxt = !(irq_ack_strobe_n_r && in_strobe);

	// Writes enable at once; reads wait half a state for the bus to turn
	assign den_on = (wr_r ? in_strobe :
		(in_strobe && !((st_nxt == MMBC_S_T2) && (ph_nxt == `MMBC_PH_HIGH))))
		|| ((st_nxt == MMBC_S_T4) && (ph_nxt == `MMBC_PH_HIGH));

	assign dir_nxt = wr_nxt ? `MMBC_DIR_TX : `MMBC_DIR_RX;
	assign done_nxt = (st_nxt == MMBC_S_T4) && (st_r != MMBC_S_T4);

	// ------------------------------------------------------------------
	// Output flops
	// ------------------------------------------------------------------

	// Floated lines hold the pull-up level so the wire reads one
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			cyc_ack_o <= 1'b0;
			cyc_done_o <= 1'b0;
			mem_io_sel_o <= `MMBC_FLOAT_LVL;
			mem_io_sel_oe_o <= `MMBC_RST_DRIVE;
			store_strobe_n_o <= `MMBC_STROBE_IDLE;
			store_strobe_n_oe_o <= `MMBC_RST_DRIVE;
			irq_ack_strobe_n_o <= `MMBC_STROBE_IDLE;
			addr_latch_o <= `MMBC_RST_ALE;
			xcvr_direction_o <= `MMBC_FLOAT_LVL;
			xcvr_direction_oe_o <= `MMBC_RST_DRIVE;
			xcvr_output_enable_n_o <= `MMBC_STROBE_IDLE;
			xcvr_output_enable_n_oe_o <= `MMBC_RST_DRIVE;
			bus_grant_out_o <= `MMBC_RST_GRANT;
		end
		else
		begin
			cyc_ack_o <= take_cyc;
			cyc_done_o <= done_nxt;
			mem_io_sel_o <= drv_nxt ? mio_nxt : `MMBC_FLOAT_LVL;
			mem_io_sel_oe_o <= drv_nxt;
			store_strobe_n_o <= drv_nxt ? wr_n_nxt : `MMBC_FLOAT_LVL;
			store_strobe_n_oe_o <= drv_nxt;
			irq_ack_strobe_n_o <= irq_ack_strobe_n_n_nxt;
			addr_latch_o <= ale_nxt;
			xcvr_direction_o <= drv_nxt ? dir_nxt : `MMBC_FLOAT_LVL;
			xcvr_direction_oe_o <= drv_nxt;
			xcvr_output_enable_n_o <= drv_nxt ? !den_on : `MMBC_FLOAT_LVL;
			xcvr_output_enable_n_oe_o <= drv_nxt;
			bus_grant_out_o <= (st_nxt == MMBC_S_HOLD);
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------

	default clocking a_clk @(posedge ref_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	// Strobe low through both halves of T2 and T3
	sequence s_strobe_low_two_states(sig);
		!sig [*4];
	endsequence

	sequence s_den_late_start;
		xcvr_output_enable_n_o ##1 !xcvr_output_enable_n_o;
	endsequence

	a_strap_gates: assert property (
		!strap_s |=> !cyc_ack_o && !bus_grant_out_o)
		else $error("cycle or grant without minimum mode strap");

	a_mio_io_for_irq_ack_strobe_n: assert property (
		$fell(irq_ack_strobe_n_o) |-> mem_io_sel_o == `MMBC_MIO_IO)
		else $error("select not low during acknowledge");

	a_mio_stable_cycle: assert property (
		(st_r inside {MMBC_S_T1, MMBC_S_T2, MMBC_S_T3, MMBC_S_TW})
		|=> $stable(mem_io_sel_o) && $stable(xcvr_direction_o))
		else $error("select or direction moved inside a cycle");

	a_grant_floats: assert property (
		$rose(bus_grant_out_o) |-> !mem_io_sel_oe_o && !store_strobe_n_oe_o
		&& !xcvr_direction_oe_o && !xcvr_output_enable_n_oe_o)
		else $error("control lines driven while grant rises");

	a_float_level_one: assert property (
		bus_grant_out_o |-> mem_io_sel_o && store_strobe_n_o
		&& xcvr_direction_o && xcvr_output_enable_n_o)
		else $error("floated line not held at one");

	a_wr_span: assert property (
		$fell(store_strobe_n_o) |-> s_strobe_low_two_states(store_strobe_n_o))
		else $error("store strobe shorter than two states");

	a_irq_ack_strobe_n_span: assert property (
		$fell(irq_ack_strobe_n_o) |->
		s_strobe_low_two_states(irq_ack_strobe_n_o))
		else $error("acknowledge strobe shorter than two states");

	a_irq_ack_strobe_n_idle_hold: assert property (
		bus_grant_out_o |-> irq_ack_strobe_n_o && !addr_latch_o)
		else $error("strobe or latch pulse active during grant");

	a_ale_one_phase: assert property (
		$rose(addr_latch_o) |-> ph_r == `MMBC_PH_LOW ##1 !addr_latch_o
		##1 st_r == MMBC_S_T2)
		else $error("latch pulse not one low phase of state one");

	a_den_read_late: assert property (
		$fell(irq_ack_strobe_n_o) |-> s_den_late_start)
		else $error("enable not delayed half a state for read");

	a_den_write_early: assert property (
		$fell(store_strobe_n_o) |-> !xcvr_output_enable_n_o
		&& $past(xcvr_output_enable_n_o))
		else $error("enable not with store strobe");

	a_den_ends_mid_t4: assert property (
		(st_r == MMBC_S_T4 && ph_r == `MMBC_PH_HIGH && drv_r)
		|-> !xcvr_output_enable_n_o ##1 xcvr_output_enable_n_o)
		else $error("enable not ending in mid final state");

	a_grant_mid_state: assert property (
		$rose(bus_grant_out_o) |-> ph_r == `MMBC_PH_LOW)
		else $error("grant not in middle of a state");

	a_grant_drop: assert property (
		(bus_grant_out_o && !hold_s) |-> ##[1:2] !bus_grant_out_o)
		else $error("grant held after request dropped");

	a_wait_on_ready: assert property (
		(st_r == MMBC_S_T3 && ph_r == `MMBC_PH_LOW && !ready_s)
		|=> st_r == MMBC_S_TW)
		else $error("no wait state while not ready");

	a_latch_one_cycle: assert property (
		addr_latch_o |=> !addr_latch_o)
		else $error("latch pulse longer than one phase");

	a_store_excl_irq_ack_strobe_n: assert property (
		!irq_ack_strobe_n_o |-> store_strobe_n_o)
		else $error("store strobe during acknowledge cycle");

	a_store_dir_tx: assert property (
		!store_strobe_n_o |-> xcvr_direction_o == `MMBC_DIR_TX)
		else $error("direction not transmit during write");

	a_den_with_store: assert property (
		!store_strobe_n_o |-> !xcvr_output_enable_n_o)
		else $error("enable off while store strobe active");

endmodule

// *** verification/mmbc_far_end.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Slow memory or IO device on the far side
// ----------------------------------------
module mmbc_far_end
(
	input wire logic ref_clk_i,
	input wire logic addr_latch_i,
	input wire logic [3:0] stall_i,
	output logic ready_o
);
	logic [3:0] cnt_r = 4'h0;
	// Each latch pulse starts a stall; zero stall answers at once
	always_ff @(posedge ref_clk_i)
	begin
		if (addr_latch_i)
			cnt_r <= stall_i;
		else if (cnt_r != 4'h0)
			cnt_r <= cnt_r - 4'h1;
	end
	assign ready_o = (cnt_r == 4'h0);
endmodule

// *** verification/mmbc_bus_control_tb.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Bench for the bus control block
// ----------------------------------------
module mmbc_bus_control_tb;
	import mmbc_pkg::*;
	logic ref_clk_i, reset_n_i, bus_req_i, ready_i, cyc_req_i;
	logic cyc_mem_i, cyc_write_i, cyc_irq_ack_strobe_n_i, cyc_ack_o, cyc_done_o;
	logic mem_io_sel_o, mem_io_sel_oe_o, store_strobe_n_o;
	logic store_strobe_n_oe_o, irq_ack_strobe_n_o, addr_latch_o;
	logic xcvr_direction_o, xcvr_direction_oe_o, xcvr_output_enable_n_o;
	logic xcvr_output_enable_n_oe_o, bus_grant_out_o;
	logic [3:0] stall;
	logic [7:0] latch_at, latch_cnt, done_at, en_first, en_cnt, st_cnt;
	logic [7:0] ia_cnt;
	logic strap;
	int fail_count = 0;
	int comparisons = 0;
	wire [3:0] oe4 = {mem_io_sel_oe_o, store_strobe_n_oe_o,
		xcvr_direction_oe_o, xcvr_output_enable_n_oe_o};

	// Strap is driven so that a strapped-low part can be shown idle
	mmbc_bus_control i_mmbc_bus_control
	(
		.ref_clk_i, .reset_n_i, .mode_strap_i(strap), .bus_req_i, .ready_i,
		.cyc_req_i, .cyc_mem_i, .cyc_write_i, .cyc_irq_ack_strobe_n_i, .cyc_ack_o,
		.cyc_done_o, .mem_io_sel_o, .mem_io_sel_oe_o, .store_strobe_n_o,
		.store_strobe_n_oe_o, .irq_ack_strobe_n_o, .addr_latch_o,
		.xcvr_direction_o, .xcvr_direction_oe_o, .xcvr_output_enable_n_o,
		.xcvr_output_enable_n_oe_o, .bus_grant_out_o
	);
	mmbc_far_end i_mmbc_far_end
	(
		.ref_clk_i, .addr_latch_i(addr_latch_o), .stall_i(stall),
		.ready_o(ready_i)
	);

	initial
	begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	task automatic final_report;
		if (fail_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// One core cycle; tallies pin activity per clock, ack cycle is 1
	task automatic do_cycle(input logic m, w, ia, input logic [3:0] st);
		logic [7:0] t;
		stall = st;
		cyc_mem_i = m;
		cyc_write_i = w;
		cyc_irq_ack_strobe_n_i = ia;
		cyc_req_i = 1'b1;
		{latch_at, latch_cnt, done_at, en_first} = 32'h0;
		{en_cnt, st_cnt, ia_cnt} = 24'h0;
		t = 8'h00;
		while (cyc_ack_o !== 1'b1 && t < 8'h14)
		begin
			@(posedge ref_clk_i);
			#2;
			t++;
		end
		chk(cyc_ack_o, 8'h01);
		cyc_req_i = 1'b0;
		for (t = 8'h01; t < 8'h18; t++)
		begin
			if (done_at == 8'h00)
			begin
				chk(mem_io_sel_o, m & ~ia);
				chk(xcvr_direction_o, w & ~ia);
			end
			if (cyc_done_o === 1'b1)
				done_at = t;
			if (addr_latch_o === 1'b1)
			begin
				latch_at = t;
				latch_cnt++;
			end
			if (xcvr_output_enable_n_o === 1'b0)
			begin
				en_cnt++;
				if (en_first == 8'h00)
					en_first = t;
			end
			if (store_strobe_n_o === 1'b0)
				st_cnt++;
			if (irq_ack_strobe_n_o === 1'b0)
				ia_cnt++;
			@(posedge ref_clk_i);
			#2;
		end
	endtask

	task automatic read_mem_test;
		do_cycle(1'b1, 1'b0, 1'b0, 4'h0);
		chk(latch_at, 8'h03);
		chk(latch_cnt, 8'h01);
		chk(done_at, 8'h08);
		chk(en_first, 8'h05);
		chk(en_cnt, 8'h04);
		chk(st_cnt + ia_cnt, 8'h00);
	endtask

	// Slow IO write: waits must stretch strobe and enable alike
	task automatic write_io_test;
		do_cycle(1'b0, 1'b1, 1'b0, 4'h6);
		chk(done_at > 8'h08, 8'h01);
		chk(done_at[0], 8'h00);
		chk(done_at, 8'h0e);
		chk(latch_at, 8'h03);
		chk(en_first, 8'h04);
		chk(en_cnt, done_at - 8'h03);
		chk(st_cnt, done_at - 8'h04);
	endtask

	task automatic irq_ack_strobe_n_test;
		do_cycle(1'b1, 1'b1, 1'b1, 4'h0);
		chk(ia_cnt, 8'h04);
		chk(st_cnt, 8'h00);
		chk(en_first, 8'h05);
		chk(done_at, 8'h08);
	endtask

	// A strapped-low part must take no cycle even with a request up
	task automatic strap_test;
		strap = 1'b0;
		repeat (3) @(posedge ref_clk_i);
		#2;
		cyc_req_i = 1'b1;
		repeat (8)
		begin
			@(posedge ref_clk_i);
			#2;
			chk({cyc_ack_o, addr_latch_o, bus_grant_out_o}, 8'h00);
		end
		cyc_req_i = 1'b0;
		strap = 1'b1;
		repeat (3) @(posedge ref_clk_i);
		#2;
	endtask

	// A pending core request must wait out the whole grant
	task automatic hold_test;
		logic [7:0] n;
		bus_req_i = 1'b1;
		n = 8'h00;
		while (bus_grant_out_o !== 1'b1 && n < 8'h0a)
		begin
			@(posedge ref_clk_i);
			#2;
			n++;
		end
		chk(bus_grant_out_o, 8'h01);
		chk(oe4, 8'h00);
		cyc_req_i = 1'b1;
		repeat (6)
		begin
			@(posedge ref_clk_i);
			#2;
			chk({cyc_ack_o, addr_latch_o, irq_ack_strobe_n_o}, 8'h01);
		end
		cyc_req_i = 1'b0;
		bus_req_i = 1'b0;
		repeat (6) @(posedge ref_clk_i);
		#2;
		chk(bus_grant_out_o, 8'h00);
		chk(oe4, 8'h00);
		do_cycle(1'b1, 1'b0, 1'b0, 4'h0);
		chk(oe4, 8'h0f);
		chk(latch_at, 8'h03);
	endtask

	initial
	begin
		#50000;
		fail_count++;
		final_report;
	end

	initial
	begin
		{reset_n_i, bus_req_i, cyc_req_i} = 3'h0;
		{cyc_mem_i, cyc_write_i, cyc_irq_ack_strobe_n_i} = 3'h0;
		stall = 4'h0;
		strap = 1'b1;
		repeat (4) @(posedge ref_clk_i);
		#2;
		chk({oe4, bus_grant_out_o, addr_latch_o}, 8'h3c);
		reset_n_i = 1'b1;
		repeat (2) @(posedge ref_clk_i);
		#2;
		read_mem_test;
		write_io_test;
		irq_ack_strobe_n_test;
		strap_test;
		hold_test;
		final_report;
	end
endmodule
